/* src/urif_pkg.sv */
// package: register map, field layout and state record of the receive-ready flag block
package urif_pkg;

  localparam int          URIF_DATA_W     = 32;
  localparam int          URIF_ADDR_W     = 8;
  localparam int          URIF_CHAR_W     = 9;
  localparam int          URIF_FIFO_DEPTH = 2;

  // register byte offsets
  localparam logic [7:0]  OFS_RX_DATA     = 8'h00;
  localparam logic [7:0]  OFS_RX_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_PERIPH_FLAG = 8'h08;
  localparam logic [7:0]  OFS_PERIPH_EN   = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_CTRL    = 8'h10;
  localparam logic [7:0]  OFS_EVT_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_EVT_MASK    = 8'h18;

  // field positions
  localparam int          BIT_CONT_RX_EN  = 0;
  localparam int          BIT_SYNC_MODE   = 1;
  localparam int          BIT_PORT_EN     = 2;
  localparam int          BIT_RX_READY    = 5;
  localparam int          BIT_RX_IRQ_EN   = 5;
  localparam int          BIT_PERIPH_IRQ  = 6;
  localparam int          BIT_GLOBAL_IRQ  = 7;
  localparam int          BIT_EVT_CHAR    = 0;
  localparam int          BIT_EVT_OVERRUN = 1;
  localparam int          URIF_EVT_W      = 2;

  // reset values
  localparam logic [2:0]  RST_RX_CTRL     = 3'h0;
  localparam logic [1:0]  RST_EVT         = 2'h0;

  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic [1:0][URIF_CHAR_W-1:0] mem;
    logic                        rd_ptr;
    logic [1:0]                  count;
    logic [2:0]                  rx_ctrl;
    logic                        rx_irq_enable;
    logic                        peripheral_irq_enable;
    logic                        global_irq_enable;
    logic [URIF_EVT_W-1:0]       evt_status;
    logic [URIF_EVT_W-1:0]       evt_mask;
    logic                        aw_got;
    logic [URIF_ADDR_W-1:0]      aw_addr;
    logic                        w_got;
    logic [URIF_DATA_W-1:0]      w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [URIF_DATA_W-1:0]      rdata;
    logic [1:0]                  rresp;
  } urif_state_t;

  typedef struct packed {
    logic                   valid;
    logic [URIF_CHAR_W-1:0] data;
  } urif_char_t;

endpackage

/* src/urif_top.sv */
// receive fifo, receive-ready flag and interrupt gating behind an axi4-lite slave
//
// How it works
// - flag high when enabled and fifo holds data
// - flag read-only, driven only by fifo and enable
// - request needs flag and all three enables
// - flag ignores every interrupt enable bit
// - fifo keeps two complete received characters
// - each data register read of a non-empty fifo pops one character
`timescale 1ns/1ps

module urif_top
  import urif_pkg::*;
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire urif_pkg::urif_char_t           rx_char,
  output logic                                rx_char_ready,
  output logic                                rx_ready_flag,
  output logic                                rx_irq_req,
  output logic                                irq,
  input  wire logic [urif_pkg::URIF_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [urif_pkg::URIF_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [urif_pkg::URIF_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [urif_pkg::URIF_DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready
);
  import urif_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge, used for the rx control and event mask registers
  function automatic logic [7:0] lane0(input logic [7:0] old_v, input logic [31:0] wd, input logic [3:0] st);
    lane0 = st[0] ? wd[7:0] : old_v;
  endfunction

  function automatic logic is_mapped(input logic [URIF_ADDR_W-1:0] a);
    is_mapped = (a == OFS_RX_DATA) || (a == OFS_RX_CTRL) || (a == OFS_PERIPH_FLAG) ||
                (a == OFS_PERIPH_EN) || (a == OFS_IRQ_CTRL) || (a == OFS_EVT_STATUS) ||
                (a == OFS_EVT_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  urif_state_t s_q;
  urif_state_t s_d;

  logic                   rx_enabled;
  logic                   fifo_empty;
  logic                   fifo_full;
  logic                   push;
  logic                   pop;
  logic                   aw_hs;
  logic                   w_hs;
  logic                   ar_hs;
  logic                   have_aw;
  logic                   have_w;
  logic                   do_write;
  logic [URIF_ADDR_W-1:0] wr_addr;
  logic [URIF_DATA_W-1:0] wr_data;
  logic [3:0]             wr_strb;
  logic [7:0]             wr_byte;
  logic [URIF_CHAR_W-1:0] head;
  logic [URIF_EVT_W-1:0]  evt_set;
  logic [URIF_DATA_W-1:0] rd_val;
  logic                   status_rd;

  ////////////////////////////////////////////////////////////////////////////
  // combinational view

  // receive path only runs in asynchronous mode with the port on
  assign rx_enabled    = s_q.rx_ctrl[BIT_CONT_RX_EN] & ~s_q.rx_ctrl[BIT_SYNC_MODE] &
                         s_q.rx_ctrl[BIT_PORT_EN];
  assign fifo_empty    = (s_q.count == 2'h0);
  assign fifo_full     = (s_q.count == 2'h2);
  assign head          = s_q.mem[s_q.rd_ptr];

  // flag follows occupancy and enable only, no interrupt enable bit gates it
  assign rx_ready_flag = rx_enabled & ~fifo_empty;
  assign rx_irq_req    = rx_ready_flag & s_q.rx_irq_enable &
                         s_q.peripheral_irq_enable & s_q.global_irq_enable;
  assign irq           = |(s_q.evt_status & s_q.evt_mask);

  // a full fifo still refuses while a pop frees a slot in the same cycle;
  // simpler timing for the shifter, costs one cycle of stall at most
  assign rx_char_ready = rx_enabled & ~fifo_full;
  assign push          = rx_char.valid & rx_char_ready;

  assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign have_aw  = s_q.aw_got | aw_hs;
  assign have_w   = s_q.w_got | w_hs;
  assign do_write = have_aw & have_w;
  assign wr_addr  = s_q.aw_got ? s_q.aw_addr : s_axi_awaddr;
  assign wr_data  = s_q.w_got ? s_q.w_data : s_axi_wdata;
  assign wr_strb  = s_q.w_got ? s_q.w_strb : s_axi_wstrb;
  assign wr_byte  = wr_data[7:0];

  // one pop per accepted read of the data register, never on an empty fifo
  assign pop       = ar_hs & (s_axi_araddr == OFS_RX_DATA) & ~fifo_empty;
  assign status_rd = ar_hs & (s_axi_araddr == OFS_EVT_STATUS);

  // a drop on a full fifo is reported, the character itself is lost
  always_comb begin
    evt_set                  = '0;
    evt_set[BIT_EVT_CHAR]    = push;
    evt_set[BIT_EVT_OVERRUN] = rx_char.valid & rx_enabled & fifo_full;
  end

  always_comb begin
    rd_val = '0;
    unique case (s_axi_araddr)
      OFS_RX_DATA: begin
        rd_val[URIF_CHAR_W-1:0] = fifo_empty ? '0 : head;
      end
      OFS_RX_CTRL: begin
        rd_val[2:0] = s_q.rx_ctrl;
      end
      OFS_PERIPH_FLAG: begin
        rd_val[BIT_RX_READY] = rx_ready_flag;
      end
      OFS_PERIPH_EN: begin
        rd_val[BIT_RX_IRQ_EN] = s_q.rx_irq_enable;
      end
      OFS_IRQ_CTRL: begin
        rd_val[BIT_PERIPH_IRQ] = s_q.peripheral_irq_enable;
        rd_val[BIT_GLOBAL_IRQ] = s_q.global_irq_enable;
      end
      OFS_EVT_STATUS: begin
        rd_val[URIF_EVT_W-1:0] = s_q.evt_status;
      end
      OFS_EVT_MASK: begin
        rd_val[URIF_EVT_W-1:0] = s_q.evt_mask;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // fifo
    if (push) begin
      s_d.mem[s_q.rd_ptr ^ s_q.count[0]] = rx_char.data;
    end
    if (pop) begin
      s_d.rd_ptr = ~s_q.rd_ptr;
    end
    unique case ({push, pop})
      2'b10: s_d.count = s_q.count + 2'h1;
      2'b01: s_d.count = s_q.count - 2'h1;
      default: s_d.count = s_q.count;
    endcase

    // write channel capture
    if (aw_hs) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // register writes; the flag register takes no write at all
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (wr_addr)
        OFS_RX_CTRL: begin
          s_d.rx_ctrl = 3'(lane0({5'h0, s_q.rx_ctrl}, wr_data, wr_strb));
        end
        OFS_PERIPH_EN: begin
          s_d.rx_irq_enable = wr_strb[0] ? wr_byte[BIT_RX_IRQ_EN] : s_q.rx_irq_enable;
        end
        OFS_IRQ_CTRL: begin
          if (wr_strb[0]) begin
            s_d.peripheral_irq_enable = wr_byte[BIT_PERIPH_IRQ];
            s_d.global_irq_enable     = wr_byte[BIT_GLOBAL_IRQ];
          end
        end
        OFS_EVT_MASK: begin
          s_d.evt_mask = URIF_EVT_W'(lane0({6'h0, s_q.evt_mask}, wr_data, wr_strb));
        end
        default: begin
          s_d.rx_ctrl = s_q.rx_ctrl;
        end
      endcase
    end

    // sticky events: read clears, a new event in the same cycle survives
    if (status_rd) begin
      s_d.evt_status = '0;
    end
    s_d.evt_status = s_d.evt_status | evt_set;

    // read channel
    if (ar_hs) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q                       <= '0;
      s_q.rx_ctrl               <= RST_RX_CTRL;
      s_q.evt_status            <= RST_EVT;
      s_q.evt_mask              <= RST_EVT;
      s_q.bresp                 <= RESP_OKAY;
      s_q.rresp                 <= RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* verification/urif_rx_src.sv */
// far-side stand-in: hands completed characters to the receive fifo
`timescale 1ns/1ps
module urif_rx_src (
  input  wire logic                            aclk,
  input  wire logic                            send,
  input  wire logic [urif_pkg::URIF_CHAR_W-1:0] din,
  output urif_pkg::urif_char_t                 rx_char
);
  import urif_pkg::*;
  // whole character as one pulse; data inverted every cycle between pulses, so it equals the last value every other cycle
  always_ff @(posedge aclk) begin
    rx_char.valid <= send;
    rx_char.data  <= send ? din : ~rx_char.data;
  end
endmodule

/* verification/urif_properties.sv */
// checker: port-level properties of the receive-ready flag block
`timescale 1ns/1ps
module urif_properties (
  input wire logic                             aclk,
  input wire logic                             aresetn,
  input wire urif_pkg::urif_char_t             rx_char,
  input wire logic                             rx_char_ready,
  input wire logic                             rx_ready_flag,
  input wire logic                             rx_irq_req,
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_awready,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_wready,
  input wire logic                             s_axi_bvalid,
  input wire logic [urif_pkg::URIF_ADDR_W-1:0] s_axi_araddr,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic                             s_axi_rvalid
);
  import urif_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] cnt_q;
  logic       put, pop, wr;
  // occupancy shadow; a write may change the enable, so checks expecting the flag high skip those edges
  assign put = rx_char.valid && rx_char_ready;
  assign pop = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_RX_DATA;
  assign wr  = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'(put) - 2'(pop && cnt_q != 2'h0);
  end
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  a_irq_needs_flag: assert property (rx_irq_req |-> rx_ready_flag) else $error("request without flag");
  a_char_sets_flag: assert property (put && !wr |=> rx_ready_flag) else $error("flag missed");
  a_fifo_two_deep: assert property (cnt_q == 2'h2 |-> !rx_char_ready) else $error("third held");
  a_empty_no_flag: assert property (cnt_q == 2'h0 |-> !rx_ready_flag) else $error("flag on empty");
  a_flag_holds: assert property (rx_ready_flag && !pop && !wr |=> rx_ready_flag) else $error("flag lost");
  a_pop_one: assert property (pop && cnt_q == 2'h2 && rx_ready_flag && !wr |=> rx_ready_flag) else $error("pop two");
  a_pop_clears: assert property (pop && cnt_q == 2'h1 && !put |=> !rx_ready_flag) else $error("flag stuck");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid) else $error("no write answer");
endmodule
bind urif_top urif_properties u_props (.aclk, .aresetn, .rx_char, .rx_char_ready, .rx_ready_flag, .rx_irq_req,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);

/* verification/tb_top.sv */
// testbench: register-level tests of the receive-ready flag block
`timescale 1ns/1ps
module tb_top;
  import urif_pkg::*;
  logic        aclk, aresetn, send, rx_char_ready, rx_ready_flag, rx_irq_req, irq;
  logic [8:0]  din;
  urif_char_t  rx_char;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_count, compares;
  urif_top dut (.aclk, .aresetn, .rx_char, .rx_char_ready, .rx_ready_flag, .rx_irq_req, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  urif_rx_src src (.aclk, .send, .din, .rx_char);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ready is judged at the falling edge, so the handshake is known before the rising edge acts on it
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hr, hb, hd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int n = 0; n < 20; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hr = s_axi_arvalid && s_axi_arready;
      hb = s_axi_bvalid && s_axi_bready;
      hd = s_axi_rvalid && s_axi_rready;
      if (hb) r = s_axi_bresp;
      if (hd) q = s_axi_rdata;
      if (hd) r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) s_axi_arvalid <= 1'b0;
      if (hb || hd) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(negedge aclk);
  endtask
  task snd(input logic [8:0] d);
    @(posedge aclk);
    send <= 1'b1;
    din <= d;
    @(posedge aclk);
    send <= 1'b0;
    repeat (2) @(negedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    err_count++;
    finish_test;
  end
  initial begin
    {send, din, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn, err_count, compares} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, OFS_RX_CTRL, 32'h0); chk(q, 32'h0);
    snd(9'h1A5); chk(rx_ready_flag, 1'b0);
    bus(1'b1, OFS_RX_CTRL, 32'h7); snd(9'h1A5); chk(rx_ready_flag, 1'b0);
    bus(1'b0, OFS_EVT_STATUS, 32'h0); chk(q, 32'h0);
    bus(1'b1, OFS_RX_CTRL, 32'h5);
    // three characters back to back: the third meets a full fifo
    @(posedge aclk);
    send <= 1'b1;
    din <= 9'h1A5;
    @(posedge aclk);
    din <= 9'h05A;
    @(posedge aclk);
    din <= 9'h0C3;
    @(posedge aclk);
    send <= 1'b0;
    repeat (2) @(negedge aclk);
    chk(rx_char_ready, 1'b0);
    chk(rx_ready_flag, 1'b1);
    bus(1'b1, OFS_PERIPH_FLAG, 32'h0); chk(r, RESP_OKAY);
    bus(1'b0, OFS_PERIPH_FLAG, 32'h0); chk(q, 32'h20);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_PERIPH_EN, {26'h0, i[0], 5'h0});
      bus(1'b1, OFS_IRQ_CTRL, {24'h0, i[2:1], 6'h0});
      chk(rx_irq_req, i == 7);
      chk(rx_ready_flag, 1'b1);
    end
    bus(1'b1, OFS_EVT_MASK, 32'h2); chk(irq, 1'b1);
    bus(1'b1, OFS_EVT_MASK, 32'h0); chk(irq, 1'b0);
    bus(1'b1, OFS_EVT_MASK, 32'h3);
    bus(1'b0, OFS_EVT_STATUS, 32'h0); chk(q, 32'h3);
    chk(irq, 1'b0);
    bus(1'b0, OFS_RX_DATA, 32'h0); chk(q, 32'h1A5);
    chk(rx_ready_flag, 1'b1);
    bus(1'b0, OFS_RX_DATA, 32'h0); chk(q, 32'h05A);
    chk(rx_ready_flag, 1'b0);
    chk(rx_irq_req, 1'b0);
    bus(1'b0, OFS_RX_DATA, 32'h0); chk(q, 32'h0);
    // disabling hides the flag but keeps the character
    snd(9'h0F0); bus(1'b1, OFS_RX_CTRL, 32'h1); chk(rx_ready_flag, 1'b0);
    bus(1'b1, OFS_RX_CTRL, 32'h5); chk(rx_ready_flag, 1'b1);
    bus(1'b0, OFS_RX_DATA, 32'h0); chk(q, 32'h0F0);
    bus(1'b0, 8'h40, 32'h0); chk(r, RESP_SLVERR);
    bus(1'b1, 8'h40, 32'h1); chk(r, RESP_SLVERR);
    finish_test;
  end
endmodule
